// ---- irm_params.svh ----
// Offsets, field positions and reset values for the isochronous receive match filter
`ifndef IRM_PARAMS_SVH
`define IRM_PARAMS_SVH

`define IRM_NUM_CTX 4
`define IRM_MATCH_BASE 16'h410C
`define IRM_CTRL_BASE 16'h4100
`define IRM_CTX_STRIDE 16'h0020

`define IRM_TAG11_BIT 31
`define IRM_TAG10_BIT 30
`define IRM_TAG01_BIT 29
`define IRM_TAG00_BIT 28
`define IRM_RSVD_HI_BIT 27
`define IRM_CYC_HI 26
`define IRM_CYC_LO 12
`define IRM_SYNC_HI 11
`define IRM_SYNC_LO 8
`define IRM_RSVD_LO_BIT 7
`define IRM_RESTRICT_BIT 6
`define IRM_CHAN_HI 5
`define IRM_CHAN_LO 0

`define IRM_CTRL_CYC_EN_BIT 29
`define IRM_CTRL_RUN_BIT 15
`define IRM_CTRL_WAIT_BIT 14
`define IRM_CTRL_ACTIVE_BIT 10

`define IRM_MATCH_WMASK 32'hF7FF_FF7F
`define IRM_CTRL_WMASK 32'h2000_8000
`define IRM_MATCH_RESET 32'h0000_0000
`define IRM_CTRL_RESET 32'h0000_0000
`define IRM_WAIT_SYNC 2'h3

`endif

// ---- irm_pkg.sv ----
// Types shared by the isochronous receive match filter
package irm_pkg;
    typedef logic [5:0] chan_t;
    typedef logic [1:0] tag_t;
    typedef logic [3:0] sync_t;
    typedef enum logic [2:0] {
        CTX_IDLE = 3'b001,
        CTX_ARMED = 3'b010,
        CTX_RECV = 3'b100
    } ctx_state_t;
endpackage : irm_pkg

// ---- iso_rx_context_match_filter_bench.sv ----
// Self-checking bench for the isochronous receive match filter
`timescale 1ns/1ns
`include "irm_params.svh"
module iso_rx_context_match_filter_bench;
    import irm_pkg::*;
    localparam logic [15:0] m0 = `IRM_MATCH_BASE;
    localparam logic [15:0] c0 = `IRM_CTRL_BASE;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [31:0] cycle_timer = 32'h0000_0000;
    logic [3:0] desc_load = 4'h0;
    logic [7:0] desc_wait = 8'h00;
    logic in_valid, in_ready, out_valid;
    logic out_ready = 1'b0;
    logic [3:0] out_ctx;
    chan_t in_channel, out_channel;
    tag_t in_tag, out_tag;
    sync_t in_sync, out_sync;
    int failures = 0;
    int samples_checked = 0;
    logic [31:0] rd;

    always #25 sys_clk = ~sys_clk;

    iso_rx_match_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cycle_timer(cycle_timer),
        .desc_load(desc_load), .desc_wait(desc_wait), .in_valid(in_valid), .in_ready(in_ready),
        .in_channel(in_channel), .in_tag(in_tag), .in_sync(in_sync), .out_valid(out_valid),
        .out_ready(out_ready), .out_ctx(out_ctx), .out_channel(out_channel), .out_tag(out_tag),
        .out_sync(out_sync));
    link_src src (.sys_clk(sys_clk), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
        .in_channel(in_channel), .in_tag(in_tag), .in_sync(in_sync));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Classic single cycle; request held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [15:0] adr, input logic [31:0] dat);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_xfer
    task automatic rdchk(input logic [15:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdchk
    // Compare the head of the output buffer, then pop it
    task automatic look(input logic [3:0] ctx, input chan_t ch, input tag_t tg, input sync_t sy);
        chk({15'h0000, out_valid, out_ctx, out_channel, out_tag, out_sync}, {15'h0000, 1'b1, ctx, ch, tg, sy});
        @(posedge sys_clk);
        out_ready <= 1'b1;
        @(posedge sys_clk);
        out_ready <= 1'b0;
    endtask : look
    // Offer a header; an empty mask means it must be dropped
    task automatic pkt(input chan_t ch, input tag_t tg, input sync_t sy, input logic [3:0] ctx);
        src.offer(ch, tg, sy);
        @(posedge sys_clk);
        #1;
        if (ctx == 4'h0) chk({31'h0, out_valid}, 32'h0000_0000);
        else look(ctx, ch, tg, sy);
    endtask : pkt
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // Hang guard, far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk(m0, 32'h0000_0000);
        rdchk(c0, 32'h0000_0000);
        rdchk(16'h4000, 32'h0000_0000);
        wb_xfer(1'b1, 16'h416C, 32'hFFFF_FFFF);
        rdchk(16'h416C, 32'hF7FF_FF7F);
        wb_xfer(1'b1, m0, 32'h9000_0005);
        wb_xfer(1'b1, c0, 32'h0000_8000);
        rdchk(c0, 32'h0000_8400);
        for (int t = 0; t < 4; t++) pkt(6'h05, tag_t'(t), 4'hF, (t == 0 || t == 3) ? 4'h1 : 4'h0);
        wb_xfer(1'b1, m0, 32'hF000_0005);
        for (int t = 0; t < 4; t++) pkt(6'h05, tag_t'(t), 4'hC, 4'h1);
        pkt(6'h06, 2'h0, 4'h0, 4'h0);
        pkt(6'h04, 2'h0, 4'h0, 4'h0);
        // Restricted tag 01b needs sync top bits clear
        wb_xfer(1'b1, m0, 32'hF000_0045);
        pkt(6'h05, 2'h1, 4'h4, 4'h0);
        pkt(6'h05, 2'h1, 4'h3, 4'h1);
        pkt(6'h05, 2'h2, 4'hF, 4'h1);
        pkt(6'h05, 2'h3, 4'hC, 4'h1);
        pkt(6'h05, 2'h0, 4'h8, 4'h1);
        wb_xfer(1'b1, m0, 32'hD000_0045);
        pkt(6'h05, 2'h1, 4'h0, 4'h0);
        // Fill both slots while the DMA side stalls; nothing may be lost
        wb_xfer(1'b1, m0, 32'hF000_0005);
        src.offer(6'h05, 2'h0, 4'h1);
        src.offer(6'h05, 2'h0, 4'h2);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({31'h0, in_ready}, 32'h0000_0000);
        look(4'h1, 6'h05, 2'h0, 4'h1);
        @(posedge sys_clk);
        #1;
        look(4'h1, 6'h05, 2'h0, 4'h2);
        // Sync wait from a descriptor, then acceptance continues
        wb_xfer(1'b1, m0, 32'hF000_0A05);
        @(posedge sys_clk);
        desc_load <= 4'h1;
        desc_wait <= 8'h03;
        @(posedge sys_clk);
        desc_load <= 4'h0;
        rdchk(c0, 32'h0000_C400);
        pkt(6'h05, 2'h0, 4'h5, 4'h0);
        pkt(6'h05, 2'h0, 4'hA, 4'h1);
        pkt(6'h05, 2'h0, 4'h5, 4'h1);
        rdchk(c0, 32'h0000_8400);
        // Enable low freezes state, so a wait request then is lost
        @(posedge sys_clk);
        ce <= 1'b0;
        desc_load <= 4'h1;
        desc_wait <= 8'h03;
        @(posedge sys_clk);
        desc_load <= 4'h0;
        ce <= 1'b1;
        rdchk(c0, 32'h0000_8400);
        // Stopped context, then start held off until the timer matches
        wb_xfer(1'b1, c0, 32'h0000_0000);
        pkt(6'h05, 2'h0, 4'h0, 4'h0);
        wb_xfer(1'b1, m0, 32'h1123_4005);
        wb_xfer(1'b1, c0, 32'h2000_8000);
        rdchk(c0, 32'h2000_8000);
        pkt(6'h05, 2'h0, 4'h0, 4'h0);
        @(posedge sys_clk);
        cycle_timer <= 32'hF123_4ABC;
        repeat (2) @(posedge sys_clk);
        rdchk(c0, 32'h2000_8400);
        pkt(6'h05, 2'h0, 4'h0, 4'h1);
        tally_and_finish();
    end
endmodule : iso_rx_context_match_filter_bench

// ---- iso_rx_match_top.sv ----
// Isochronous receive match filter with four contexts and a Wishbone register port
`timescale 1ns/1ns
`include "irm_params.svh"
module iso_rx_match_top (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Bus cycle timer
    input wire logic [31:0] cycle_timer,
    // Descriptor engine wait requests, one lane per context
    input wire logic [3:0] desc_load,
    input wire logic [7:0] desc_wait,
    // Received packet headers from the link
    input wire logic in_valid,
    output logic in_ready,
    input wire irm_pkg::chan_t in_channel,
    input wire irm_pkg::tag_t in_tag,
    input wire irm_pkg::sync_t in_sync,
    // Accepted packets toward the DMA
    output logic out_valid,
    input wire logic out_ready,
    output logic [3:0] out_ctx,
    output irm_pkg::chan_t out_channel,
    output irm_pkg::tag_t out_tag,
    output irm_pkg::sync_t out_sync
);
    import irm_pkg::*;

    logic [31:0] match_reg [`IRM_NUM_CTX];
    logic [31:0] ctrl_reg [`IRM_NUM_CTX];
    logic [31:0] next_match [`IRM_NUM_CTX];
    logic [31:0] next_ctrl [`IRM_NUM_CTX];
    logic [31:0] next_dat;
    logic next_ack;
    logic [31:0] lane_mask;
    logic [3:0] hit;
    logic [3:0] active;
    logic [3:0] wait_pend;
    logic [3:0] run;
    logic [3:0] cyc_en;
    logic bus_req;
    logic wr_now;
    logic pkt_take;
    logic [15:0] buf_out;

    // Byte lanes of the write
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            lane_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    end

    // Write lands at the edge where ack is seen high by the master
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign wr_now = bus_req && wb_we_i && wb_ack_o;

    // Register write decode; reserved bits forced low by the write mask
    always_comb begin
        for (int n = 0; n < `IRM_NUM_CTX; n++) begin
            next_match[n] = match_reg[n];
            next_ctrl[n] = ctrl_reg[n];
            if (wr_now && wb_adr_i == 16'(`IRM_MATCH_BASE + n * `IRM_CTX_STRIDE)) begin
                next_match[n] = (match_reg[n] & ~lane_mask) |
                                (wb_dat_i & lane_mask & `IRM_MATCH_WMASK);
            end else if (wr_now && wb_adr_i == 16'(`IRM_CTRL_BASE + n * `IRM_CTX_STRIDE)) begin
                next_ctrl[n] = (ctrl_reg[n] & ~lane_mask) |
                               (wb_dat_i & lane_mask & `IRM_CTRL_WMASK);
            end
        end
    end

    // Read decode; unmapped addresses answer with zero
    always_comb begin
        next_dat = 32'h0000_0000;
        next_ack = bus_req && !wb_ack_o;
        for (int n = 0; n < `IRM_NUM_CTX; n++) begin
            if (wb_adr_i == 16'(`IRM_MATCH_BASE + n * `IRM_CTX_STRIDE)) begin
                next_dat = match_reg[n];
            end else if (wb_adr_i == 16'(`IRM_CTRL_BASE + n * `IRM_CTX_STRIDE)) begin
                next_dat = ctrl_reg[n];
                next_dat[`IRM_CTRL_ACTIVE_BIT] = active[n];
                next_dat[`IRM_CTRL_WAIT_BIT] = wait_pend[n];
            end
        end
        if (!bus_req || wb_ack_o) begin
            next_dat = wb_dat_o;
        end
    end

    // Run bit changes only by software or reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int n = 0; n < `IRM_NUM_CTX; n++) begin
                match_reg[n] <= `IRM_MATCH_RESET;
                ctrl_reg[n] <= `IRM_CTRL_RESET;
            end
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            for (int n = 0; n < `IRM_NUM_CTX; n++) begin
                match_reg[n] <= next_match[n];
                ctrl_reg[n] <= next_ctrl[n];
            end
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // Packet is consumed when offered and the buffer has room
    assign pkt_take = in_valid && in_ready;

    // One filter per context
    for (genvar n = 0; n < `IRM_NUM_CTX; n++) begin : g_ctx
        assign run[n] = ctrl_reg[n][`IRM_CTRL_RUN_BIT];
        assign cyc_en[n] = ctrl_reg[n][`IRM_CTRL_CYC_EN_BIT];
        rx_ctx_filter u_filter (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ce(ce),
            .match(match_reg[n]),
            .run(run[n]),
            .start_on_cycle_en(cyc_en[n]),
            .timer_now(cycle_timer[`IRM_CYC_HI:`IRM_CYC_LO]),
            .pkt_take(pkt_take),
            .pkt_channel(in_channel),
            .pkt_tag(in_tag),
            .pkt_sync(in_sync),
            .desc_load(desc_load[n]),
            .desc_wait(desc_wait[n*2 +: 2]),
            .hit(hit[n]),
            .active(active[n]),
            .wait_pend(wait_pend[n])
        );
    end

    // Unmatched packets are consumed and dropped; matched ones are queued
    pair_buffer #(
        .WIDTH(16)
    ) u_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .s_valid(in_valid && (|hit)),
        .s_ready(in_ready),
        .s_data({hit, in_channel, in_tag, in_sync}),
        .m_valid(out_valid),
        .m_ready(out_ready),
        .m_data(buf_out)
    );

    assign out_ctx = buf_out[15:12];
    assign out_channel = buf_out[11:6];
    assign out_tag = buf_out[5:4];
    assign out_sync = buf_out[3:0];

    // Filter checks on context 0 stand for all four, which share one filter body
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Reserved bits watched on context 3, the one software fills with all ones
    a_rsvd_hi_zero: assert property (match_reg[3][`IRM_RSVD_HI_BIT] == 1'b0)
        else $error("match bit 27 not zero");
    a_rsvd_lo_zero: assert property (match_reg[3][`IRM_RSVD_LO_BIT] == 1'b0)
        else $error("match bit 7 not zero");
    a_cycle_write: assert property (ce && wr_now && wb_adr_i == `IRM_MATCH_BASE && wb_sel_i == 4'hF
        |=> match_reg[0][`IRM_CYC_HI:`IRM_CYC_LO] == $past(wb_dat_i[`IRM_CYC_HI:`IRM_CYC_LO]))
        else $error("cycle start value not stored");
    a_ack_single: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_tag_gate: assert property (hit[0] |-> match_reg[0][`IRM_TAG00_BIT + in_tag])
        else $error("disabled tag accepted");
    a_tag01_sync: assert property (hit[0] && in_tag == 2'h1 && match_reg[0][`IRM_RESTRICT_BIT]
        |-> in_sync[3:2] == 2'h0)
        else $error("tag 01 passed sync restriction");
    a_other_tags: assert property (active[0] && run[0] && !wait_pend[0] && in_tag != 2'h1
        && match_reg[0][`IRM_TAG00_BIT + in_tag] && in_channel == match_reg[0][5:0] |-> hit[0])
        else $error("enabled tag refused");
    a_tag01_free: assert property (active[0] && run[0] && !wait_pend[0] && in_tag == 2'h1
        && !match_reg[0][`IRM_RESTRICT_BIT] && match_reg[0][`IRM_TAG01_BIT]
        && in_channel == match_reg[0][5:0] |-> hit[0])
        else $error("tag 01 refused without restriction");
    a_chan_gate: assert property (hit[0] |-> in_channel == match_reg[0][`IRM_CHAN_HI:`IRM_CHAN_LO])
        else $error("wrong channel accepted");
    a_stop_blocks: assert property (!run[0] |-> !hit[0] ##1 (!active[0] || !$past(ce)))
        else $error("stopped context accepted");
    a_cycle_hold: assert property (ce && run[0] && cyc_en[0] && !active[0]
        && cycle_timer[`IRM_CYC_HI:`IRM_CYC_LO] != match_reg[0][`IRM_CYC_HI:`IRM_CYC_LO]
        |=> !active[0])
        else $error("context started off cycle");
    a_sync_block: assert property (wait_pend[0]
        && in_sync != match_reg[0][`IRM_SYNC_HI:`IRM_SYNC_LO] |-> !hit[0])
        else $error("sync wait bypassed");
    a_wait_arm: assert property (ce && desc_load[0] && desc_wait[1:0] == `IRM_WAIT_SYNC
        |=> wait_pend[0])
        else $error("sync wait not armed");
    a_wait_met: assert property (ce && pkt_take && hit[0] && wait_pend[0] && !desc_load[0]
        |=> !wait_pend[0])
        else $error("sync wait not released");

    c_restricted_accept: cover property (pkt_take && hit[0] && in_tag == 2'h1
        && match_reg[0][`IRM_RESTRICT_BIT]);
    c_wait_met: cover property (pkt_take && hit[0] && wait_pend[0]);
    c_buffer_full: cover property (in_valid && !in_ready);
    c_cycle_start: cover property (cyc_en[0] && !active[0] ##1 active[0]);
endmodule : iso_rx_match_top

// ---- link_src.sv ----
// Link-side model that offers received packet headers to the filter
`timescale 1ns/1ns
module link_src (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Header toward the filter
    output logic in_valid,
    input wire logic in_ready,
    output irm_pkg::chan_t in_channel,
    output irm_pkg::tag_t in_tag,
    output irm_pkg::sync_t in_sync
);
    import irm_pkg::*;
    // Idle before the first header
    initial begin
        in_valid = 1'b0;
        in_channel = 6'h00;
        in_tag = 2'h0;
        in_sync = 4'h0;
    end
    // Hold one header until taken; released fields flip so stale values never match by luck
    task automatic offer(input chan_t ch, input tag_t tg, input sync_t sy);
        wait (rst_n === 1'b1);
        @(posedge sys_clk);
        in_valid <= 1'b1;
        in_channel <= ch;
        in_tag <= tg;
        in_sync <= sy;
        do @(posedge sys_clk); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        in_channel <= ~ch;
        in_tag <= ~tg;
        in_sync <= ~sy;
    endtask : offer
endmodule : link_src

// ---- pair_buffer.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module pair_buffer #(
    parameter int WIDTH = 16
) (
    // Clock and control
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Filling side
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    // Draining side
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data
);
    logic [WIDTH-1:0] slot [2];
    logic [1:0] full;
    logic [WIDTH-1:0] next_slot [2];
    logic [1:0] next_full;
    logic push;
    logic pop;

    // Slot 0 is always the head so the output comes straight from a flop
    always_comb begin
        push = s_valid && s_ready;
        pop = full[0] && m_ready;
        next_slot[0] = slot[0];
        next_slot[1] = slot[1];
        next_full = full;
        if (pop) begin
            next_slot[0] = slot[1];
            next_full[0] = full[1];
            next_full[1] = 1'b0;
        end
        if (push) begin
            if (!next_full[0]) begin
                next_slot[0] = s_data;
                next_full[0] = 1'b1;
            end else begin
                next_slot[1] = s_data;
                next_full[1] = 1'b1;
            end
        end
    end

    // Ready is registered; it drops only when the second slot fills
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            full <= 2'h0;
            s_ready <= 1'b1;
            slot[0] <= '0;
            slot[1] <= '0;
        end else if (ce) begin
            full <= next_full;
            s_ready <= !next_full[1];
            slot[0] <= next_slot[0];
            slot[1] <= next_slot[1];
        end
    end

    assign m_valid = full[0];
    assign m_data = slot[0];
endmodule : pair_buffer

// ---- rx_ctx_filter.sv ----
// One receive context: start gate, sync wait and packet match
`timescale 1ns/1ns
`include "irm_params.svh"
module rx_ctx_filter (
    // Clock and control
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Settings from software
    input wire logic [31:0] match,
    input wire logic run,
    input wire logic start_on_cycle_en,
    input wire logic [14:0] timer_now,
    // Packet under test
    input wire logic pkt_take,
    input wire irm_pkg::chan_t pkt_channel,
    input wire irm_pkg::tag_t pkt_tag,
    input wire irm_pkg::sync_t pkt_sync,
    // Descriptor wait request
    input wire logic desc_load,
    input wire logic [1:0] desc_wait,
    // Results
    output logic hit,
    output logic active,
    output logic wait_pend
);
    import irm_pkg::*;

    ctx_state_t state;
    ctx_state_t next_state;
    logic next_wait;
    logic cyc_hit;
    logic tag_ok;
    logic sync_ok;

    // Start gate: armed until the timer reaches the start value
    always_comb begin
        cyc_hit = (timer_now == match[`IRM_CYC_HI:`IRM_CYC_LO]);
        next_state = state;
        case (state)
            CTX_IDLE: begin
                if (run) begin
                    next_state = (start_on_cycle_en && !cyc_hit) ? CTX_ARMED : CTX_RECV;
                end
            end
            CTX_ARMED: begin
                if (!run) begin
                    next_state = CTX_IDLE;
                end else if (cyc_hit) begin
                    next_state = CTX_RECV;
                end
            end
            CTX_RECV: begin
                if (!run) begin
                    next_state = CTX_IDLE;
                end
            end
            default: next_state = CTX_IDLE;
        endcase
    end

    // Match terms for the packet on offer
    always_comb begin
        case (pkt_tag)
            2'h3: tag_ok = match[`IRM_TAG11_BIT];
            2'h2: tag_ok = match[`IRM_TAG10_BIT];
            2'h1: tag_ok = match[`IRM_TAG01_BIT] &&
                           (!match[`IRM_RESTRICT_BIT] || pkt_sync[3:2] == 2'h0);
            default: tag_ok = match[`IRM_TAG00_BIT];
        endcase
        sync_ok = !wait_pend || pkt_sync == match[`IRM_SYNC_HI:`IRM_SYNC_LO];
        hit = run && state == CTX_RECV && tag_ok && sync_ok &&
              pkt_channel == match[`IRM_CHAN_HI:`IRM_CHAN_LO];
    end

    // Sync wait: a new descriptor wins over a packet meeting the old wait
    always_comb begin
        next_wait = wait_pend;
        if (pkt_take && hit) begin
            next_wait = 1'b0;
        end
        if (desc_load) begin
            next_wait = (desc_wait == `IRM_WAIT_SYNC);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= CTX_IDLE;
            wait_pend <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            wait_pend <= next_wait;
        end
    end

    assign active = (state == CTX_RECV);
endmodule : rx_ctx_filter
